// ===== rtl/wdt_core.sv
// Purpose: key-protected windowed watchdog with write-once mode register
// Assumes: slow_tick, cpu_debug and cpu_idle are synchronous to mclk
// Notes: rst_n stands for the processor reset; all state restarts on it
//
// What this block does
// - restart write only acts when the key byte is 0xa5, otherwise ignored
// - mode register takes only its first write after reset, reads still work
// - reload field gives the value loaded into the 12-bit counter on restart
// - irq enable set lets underflow or window error raise the interrupt
// - reset enable set lets underflow or window error raise a reset request
// - select bit picks processor-only reset at 1, all resets at 0
// - off bit stops the counter at 1, lets it run at 0
// - restart with counter at or below window limit reloads and restarts
// - restart with counter above window limit is an error and sets its flag
// - window limit lives in bits 27..16, reload value in bits 11..0
// - debug halt bit stops the counter while the processor is in debug
// - idle halt bit stops the counter while the system is idle
// - underflow flag is sticky until the status register is read
// - window error flag is sticky until the status register is read
// - counter steps down once per 128 slow clock ticks
// - valid restart reloads at once and restarts the 128 divider
// - accepted mode write reloads and restarts the counter
// - window error is raised even while the timer is off
module wdt_core #(
  parameter int PRESCALE = wdt_pkg::PRESCALE_DIV
) (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic rst_n, // processor reset, async, active low
  input wire logic slow_tick, // one pulse per slow clock period
  input wire logic cpu_debug, // processor in debug state
  input wire logic cpu_idle, // system in idle state
  input wire logic [wdt_pkg::ADDR_W-1:0] addr, // register byte address
  input wire logic [wdt_pkg::DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [wdt_pkg::DATA_W-1:0] rd_data, // read data, cycle after strobe
  output logic wdt_irq, // fault interrupt, level
  output logic wdt_fault, // fault toward the reset controller, level
  output logic wdt_proc_only // reset scope: 1 processor only, 0 all
);
  import wdt_pkg::*;

  // stored state
  logic [DATA_W-1:0] mode_reg;
  logic mode_locked;
  logic [CNT_W-1:0] count;
  logic underflow_flag;
  logic window_error_flag;

  // mode fields
  logic [CNT_W-1:0] counter_reload_value;
  logic [CNT_W-1:0] restart_window_limit;
  logic fault_irq_en;
  logic fault_reset_en;
  logic proc_only_reset_sel;
  logic timer_off;
  logic debug_halt_sel;
  logic idle_halt_sel;

  // decode and control
  logic hit_cr;
  logic hit_mr;
  logic hit_sr;
  logic hit_cv;
  logic mode_wr;
  logic mode_accept;
  logic key_ok;
  logic restart_cmd;
  logic in_window;
  logic restart_ok;
  logic win_err_ev;
  logic restart_any;
  logic halted;
  logic run;
  logic pre_tick;
  logic at_zero;
  logic unf_ev;
  logic fault_ev;
  logic status_rd;
  logic any_fault;

  // next values
  logic [DATA_W-1:0] next_mode;
  logic [CNT_W-1:0] next_reload;
  logic [CNT_W-1:0] next_count;
  logic next_unf;
  logic next_err;
  logic [DATA_W-1:0] next_rd_data;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] view_word;

  // field extraction from the stored mode word
  assign counter_reload_value = mode_reg[RELOAD_LSB +: CNT_W];
  assign restart_window_limit = mode_reg[WINDOW_LSB +: CNT_W];
  assign fault_irq_en = mode_reg[IRQ_EN_BIT];
  assign fault_reset_en = mode_reg[RST_EN_BIT];
  assign proc_only_reset_sel = mode_reg[PROC_SEL_BIT];
  assign timer_off = mode_reg[OFF_BIT];
  assign debug_halt_sel = mode_reg[DBG_HALT_BIT];
  assign idle_halt_sel = mode_reg[IDLE_HALT_BIT];

  // address decode
  assign hit_cr = (addr == OFF_RESTART_CTRL);
  assign hit_mr = (addr == OFF_MODE_CONFIG);
  assign hit_sr = (addr == OFF_FAULT_STATUS);
  assign hit_cv = (addr == OFF_COUNT_VIEW);

  // write-once mode register; later writes fall on the floor
  assign mode_wr = wr_en && hit_mr;
  assign mode_accept = mode_wr && !mode_locked;
  assign next_mode = mode_accept ? (wr_data & MODE_MASK) : mode_reg;

  // a wrong key aborts the whole write, not just the restart bit
  assign key_ok = (wr_data[KEY_LSB +: KEY_W] == RESTART_KEY);
  assign restart_cmd = wr_en && hit_cr && key_ok && wr_data[RESTART_BIT];

  // window check runs regardless of the off bit
  assign in_window = (count <= restart_window_limit);
  assign restart_ok = restart_cmd && in_window;
  assign win_err_ev = restart_cmd && !in_window;

  // both a valid restart and an accepted mode write restart counter and divider
  assign restart_any = mode_accept || restart_ok;

  // halting only freezes the counter, the divider keeps counting slow ticks
  assign halted = (debug_halt_sel && cpu_debug) || (idle_halt_sel && cpu_idle);
  assign run = !timer_off && !halted;

  // underflow when a tick finds the counter already at zero
  assign at_zero = (count == CNT_ZERO);
  assign unf_ev = run && pre_tick && at_zero && !restart_any;
  assign fault_ev = unf_ev || win_err_ev;

  // reload value: a fresh mode write loads its own field at once
  assign next_reload = mode_accept ? wr_data[RELOAD_LSB +: CNT_W]
                     : counter_reload_value;

  // counter: restart first, then a divided tick, else hold
  assign next_count = restart_any ? next_reload
                    : (run && pre_tick)
                      ? (at_zero ? counter_reload_value : count - CNT_ONE)
                    : count;

  // sticky flags; a new event in the clearing cycle survives the read
  assign status_rd = rd_en && hit_sr;
  assign next_unf = unf_ev || (underflow_flag && !status_rd);
  assign next_err = win_err_ev || (window_error_flag && !status_rd);
  assign any_fault = next_unf || next_err;

  // read words; reserved bits read zero
  assign status_word = {30'h0, window_error_flag, underflow_flag};
  assign view_word = {mode_locked, 19'h0, count};
  assign next_rd_data = !rd_en ? 32'h0
                      : hit_mr ? mode_reg
                      : hit_sr ? status_word
                      : hit_cv ? view_word
                      : 32'h0;

  // divide-by-128 prescaler, restarted with the counter
  wdt_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(restart_any),
    .slow_tick(slow_tick),
    .tick(pre_tick)
  );

  // mode register and its lock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET;
      mode_locked <= 1'b0;
    end else begin
      mode_reg <= next_mode;
      mode_locked <= mode_locked || mode_wr;
    end
  end

  // down counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= MODE_RESET[RELOAD_LSB +: CNT_W];
    end else begin
      count <= next_count;
    end
  end

  // status flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      underflow_flag <= 1'b0;
      window_error_flag <= 1'b0;
    end else begin
      underflow_flag <= next_unf;
      window_error_flag <= next_err;
    end
  end

  // interrupt and fault lines follow the flags, gated by the enables; scope line copies the select bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_irq <= 1'b0;
      wdt_fault <= 1'b0;
      wdt_proc_only <= 1'b0;
    end else begin
      wdt_irq <= any_fault && fault_irq_en;
      wdt_fault <= any_fault && fault_reset_en;
      wdt_proc_only <= proc_only_reset_sel;
    end
  end

  // read data stands one cycle only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // a write with the wrong key never restarts anything
  chk_bad_key_ignored: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && hit_cr && (wr_data[KEY_LSB +: KEY_W] != RESTART_KEY))
      |=> (window_error_flag == $past(window_error_flag))
          && ((count == $past(count)) || $past(pre_tick))
  ) else $error("restart acted on a wrong key");

  // once locked, the mode word no longer moves
  chk_mode_write_once: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode_locked && mode_wr) |=> $stable(mode_reg)
  ) else $error("mode register changed after its first write");

  // restart loads the stored reload field
  chk_restart_reload: assert property (
    @(posedge mclk) disable iff (!rst_n)
    restart_ok |=> (count == $past(counter_reload_value))
  ) else $error("restart did not load the reload value");

  // fault with irq enabled shows on the interrupt next cycle
  chk_irq_raised: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (fault_ev && fault_irq_en) |=> wdt_irq
  ) else $error("fault did not raise the interrupt");

  // interrupt never without its enable
  chk_irq_gated: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wdt_irq |-> $past(fault_irq_en)
  ) else $error("interrupt raised while disabled");

  // fault line never without the reset enable, and carries the scope
  chk_fault_gated: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wdt_fault |-> $past(fault_reset_en) && (wdt_proc_only == $past(proc_only_reset_sel))
  ) else $error("fault line wrong enable or scope");

  // fault with reset enabled reaches the reset controller
  chk_fault_raised: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (fault_ev && fault_reset_en) |=> wdt_fault
  ) else $error("fault did not reach the reset controller");

  // off bit freezes the counter unless restarted
  chk_off_holds: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (timer_off && !restart_any) |=> $stable(count)
  ) else $error("counter moved while the timer is off");

  // restart above the window limit sets the error flag
  chk_window_error: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (restart_cmd && (count > restart_window_limit)) |=> window_error_flag && $stable(count)
  ) else $error("window violation not flagged");

  // an accepted mode write places its fields and reloads
  chk_mode_fields: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_accept |=> (restart_window_limit == $past(wr_data[27:16]))
                    && (count == $past(wr_data[11:0]))
  ) else $error("mode write fields or reload wrong");

  // halts freeze the counter
  chk_halt_holds: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (halted && !restart_any) |=> $stable(count)
  ) else $error("counter moved while halted");

  // the counter only steps on a divided tick
  chk_tick_only: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!pre_tick && !restart_any) |=> $stable(count)
  ) else $error("counter moved without a divided tick");

  // underflow is caught in the sticky flag
  chk_underflow_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    unf_ev |=> underflow_flag ##1 (underflow_flag || $past(status_rd))
  ) else $error("underflow not recorded");

  // a status read with no new event clears both flags and the irq and fault lines
  chk_status_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (status_rd && !fault_ev) |=> !underflow_flag && !window_error_flag && !wdt_irq && !wdt_fault
  ) else $error("status read did not clear the fault state");

  // mode reads return the stored word even once locked
  chk_mode_readback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && hit_mr) |=> (rd_data == $past(mode_reg))
  ) else $error("mode read returned the wrong word");

  // status read shows the flags as they stood before the clear
  chk_status_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && hit_sr) |=> (rd_data[UNF_BIT] == $past(underflow_flag))
                          && (rd_data[ERR_BIT] == $past(window_error_flag))
  ) else $error("status read returned the wrong flags");

  // a restart inside the window never raises an error
  chk_window_ok: assert property (
    @(posedge mclk) disable iff (!rst_n)
    restart_ok |=> (window_error_flag == $past(window_error_flag))
  ) else $error("restart inside the window flagged an error");

  // a running counter above zero steps down by one on a divided tick
  chk_run_steps: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (run && pre_tick && !restart_any && !at_zero) |=> (count == $past(count) - CNT_ONE)
  ) else $error("counter did not step down on a divided tick");

  // a divided tick at zero reloads and records the underflow
  chk_underflow_reload: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (run && pre_tick && at_zero && !restart_any)
      |=> (count == $past(counter_reload_value)) && underflow_flag
  ) else $error("underflow did not reload or flag");

  // with both halt bits clear the processor states never stop the count
  chk_halt_bits_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!debug_halt_sel && !idle_halt_sel && !timer_off && pre_tick && !restart_any && !at_zero)
      |=> (count == $past(count) - CNT_ONE)
  ) else $error("counter stopped although halts are off");

  // interrupt and fault lines track the flags and their enables
  chk_lines_follow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (wdt_irq == ((underflow_flag || window_error_flag) && $past(fault_irq_en)))
      && (wdt_fault == ((underflow_flag || window_error_flag) && $past(fault_reset_en)))
  ) else $error("interrupt or fault line out of step with the flags");

  // reset scope line is a registered copy of the select bit
  chk_scope_copy: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wdt_proc_only == $past(proc_only_reset_sel)
  ) else $error("reset scope line does not follow the select bit");
endmodule

// ===== rtl/wdt_pkg.sv
// Purpose: shared constants of the windowed watchdog
// Assumes: registers sit on a 28-bit byte address space, 32-bit data
// Notes: offsets are byte addresses, all word aligned
package wdt_pkg;
  // register bus
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_RESTART_CTRL = 28'hffffe40;
  localparam logic [ADDR_W-1:0] OFF_MODE_CONFIG = 28'hffffe44;
  localparam logic [ADDR_W-1:0] OFF_FAULT_STATUS = 28'hffffe48;
  localparam logic [ADDR_W-1:0] OFF_COUNT_VIEW = 28'hffffe4c;

  // restart control fields
  localparam int KEY_LSB = 24;
  localparam int KEY_W = 8;
  localparam logic [KEY_W-1:0] RESTART_KEY = 8'ha5;
  localparam int RESTART_BIT = 0;

  // mode config fields
  localparam int CNT_W = 12;
  localparam int RELOAD_LSB = 0;
  localparam int IRQ_EN_BIT = 12;
  localparam int RST_EN_BIT = 13;
  localparam int PROC_SEL_BIT = 14;
  localparam int OFF_BIT = 15;
  localparam int WINDOW_LSB = 16;
  localparam int DBG_HALT_BIT = 28;
  localparam int IDLE_HALT_BIT = 29;
  localparam logic [DATA_W-1:0] MODE_RESET = 32'h3fff2fff;
  localparam logic [DATA_W-1:0] MODE_MASK = 32'h3fffffff;

  // fault status fields
  localparam int UNF_BIT = 0;
  localparam int ERR_BIT = 1;

  // count view fields
  localparam int LOCK_BIT = 31;

  // counter constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam int PRESCALE_DIV = 128;
endpackage

// ===== rtl/wdt_prescaler.sv
// Purpose: divides the slow clock tick stream down for the watchdog counter
// Assumes: slow_tick is a one-cycle pulse per slow clock period, on mclk
// Notes: restart clears the phase so a fresh period starts at once
module wdt_prescaler #(
  parameter int DIV = 128
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic restart, // clears the divider phase
  input wire logic slow_tick, // one pulse per slow clock period
  output logic tick // one pulse per DIV slow ticks
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] STEP = CW'(1);

  logic [CW-1:0] phase;
  logic [CW-1:0] next_phase;
  logic at_last;

  // restart wins over a slow tick in the same cycle
  assign at_last = (phase == LAST);
  assign tick = slow_tick && at_last && !restart;
  assign next_phase = restart ? '0 : slow_tick ? (at_last ? '0 : phase + STEP) : phase;

  // phase register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end
endmodule

// ===== tb/wdt_rc_model.sv
// Purpose: reset controller and interrupt sink facing the watchdog
// Assumes: fault and irq are levels synchronous to mclk
// Notes: only latches requests; it never pulls the core's reset itself
module wdt_rc_model (
  input wire logic mclk, // system clock
  input wire logic rst_n, // processor reset, active low
  input wire logic wdt_fault, // fault level from the core
  input wire logic wdt_proc_only, // reset scope from the core
  input wire logic wdt_irq, // interrupt level from the core
  output logic cpu_rst_req, // processor reset was requested
  output logic sys_rst_req, // whole system reset was requested
  output logic irq_seen // interrupt was raised
);
  timeunit 1ns;
  timeprecision 1ps;

  // latched so the bench can ask after the level has been cleared
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rst_req <= 1'b0;
      sys_rst_req <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      if (wdt_fault) begin
        cpu_rst_req <= 1'b1;
        sys_rst_req <= sys_rst_req | !wdt_proc_only;
      end
      if (wdt_irq) begin
        irq_seen <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/windowed_watchdog_timer_tb.sv
// Purpose: self-checking bench for the windowed watchdog core
// Assumes: divider shortened to 4 so underflow comes within a few hundred cycles
// Notes: counter is watched through the count view register
module windowed_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  localparam int PS = 4; // short divider, all counts scale with it
  localparam logic [DATA_W-1:0] GO = {RESTART_KEY, 24'h000001};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_tick = 1'b0;
  logic cpu_debug = 1'b0;
  logic cpu_idle = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic wdt_irq, wdt_fault, wdt_proc_only;
  logic cpu_rst_req, sys_rst_req, irq_seen;
  int fails = 0;
  int samples_checked = 0;
  int seed = 51;
  logic [CNT_W-1:0] v, w;
  logic p;

  wdt_core #(.PRESCALE(PS)) dut (.mclk(mclk), .rst_n(rst_n), .slow_tick(slow_tick),
    .cpu_debug(cpu_debug), .cpu_idle(cpu_idle), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wdt_irq(wdt_irq),
    .wdt_fault(wdt_fault), .wdt_proc_only(wdt_proc_only));
  wdt_rc_model rc (.mclk(mclk), .rst_n(rst_n), .wdt_fault(wdt_fault),
    .wdt_proc_only(wdt_proc_only), .wdt_irq(wdt_irq), .cpu_rst_req(cpu_rst_req),
    .sys_rst_req(sys_rst_req), .irq_seen(irq_seen));

  // 40 mhz
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // expected mode word: b = {off, proc, rst, irq}, h = {idle, dbg}
  function automatic logic [DATA_W-1:0] mode_of(input logic [CNT_W-1:0] rl, win,
    input logic [3:0] b, input logic [1:0] h);
    return {2'b00, h, win, b, rl};
  endfunction
  function automatic logic [DATA_W-1:0] view(input logic [CNT_W-1:0] c);
    return {1'b1, 19'h00000, c};
  endfunction

  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
    input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // bus cycles: strobe held one edge, released right after it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input string what,
    input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rd_data);
  endtask
  // slow clock pulses with a low cycle between them
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      slow_tick <= 1'b1;
      @(posedge mclk);
      slow_tick <= 1'b0;
    end
    #1;
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic summarize;
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    fails++;
    summarize;
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    v = 12'(8 + ($random(seed) & 7));
    w = v - 12'h004;
    p = 1'($random(seed));
    rd(OFF_MODE_CONFIG, "mode reset", MODE_RESET);
    rd(OFF_FAULT_STATUS, "status reset", 32'h0);
    rd(OFF_RESTART_CTRL, "control read", 32'h0);
    rd(28'hffffe50, "unmapped read", 32'h0);
    wr(OFF_MODE_CONFIG, mode_of(v, w, {1'b0, p, 2'b11}, 2'b11));
    wr(OFF_MODE_CONFIG, mode_of(12'h003, 12'h003, 4'h8, 2'b00));
    rd(OFF_MODE_CONFIG, "mode locked", mode_of(v, w, {1'b0, p, 2'b11}, 2'b11));
    rd(OFF_COUNT_VIEW, "count loaded", view(v));
    chkb("scope", p, wdt_proc_only);
    // wrong key must not even raise a window error
    wr(OFF_RESTART_CTRL, {8'h5a, 24'h000001});
    rd(OFF_FAULT_STATUS, "bad key", 32'h0);
    wr(OFF_RESTART_CTRL, GO);
    settle;
    chkb("irq on error", 1'b1, wdt_irq);
    chkb("fault on error", 1'b1, wdt_fault);
    chkb("all reset req", !p, sys_rst_req);
    rd(OFF_FAULT_STATUS, "window error", 32'h2);
    chkb("irq cleared", 1'b0, wdt_irq);
    chkb("fault cleared", 1'b0, wdt_fault);
    rd(OFF_FAULT_STATUS, "error read clears", 32'h0);
    // halts freeze the count; whole divider periods keep the phase at 0
    @(posedge mclk) cpu_debug <= 1'b1;
    tk(2 * PS);
    rd(OFF_COUNT_VIEW, "debug halt", view(v));
    @(posedge mclk) cpu_debug <= 1'b0;
    cpu_idle <= 1'b1;
    tk(2 * PS);
    rd(OFF_COUNT_VIEW, "idle halt", view(v));
    @(posedge mclk) cpu_idle <= 1'b0;
    tk(4 * PS + PS - 1);
    rd(OFF_COUNT_VIEW, "count steps", view(w));
    wr(OFF_RESTART_CTRL, GO);
    rd(OFF_COUNT_VIEW, "restart at limit", view(v));
    tk(PS - 1);
    rd(OFF_COUNT_VIEW, "divider cleared", view(v));
    tk(1 + PS * (int'(v) - 1));
    rd(OFF_COUNT_VIEW, "count at zero", view(12'h000));
    rd(OFF_FAULT_STATUS, "no flag yet", 32'h0);
    tk(PS);
    settle;
    chkb("irq on underflow", 1'b1, wdt_irq);
    rd(OFF_COUNT_VIEW, "reload after underflow", view(v));
    rd(OFF_FAULT_STATUS, "underflow", 32'h1);
    // leave an error pending, then let reset clear it
    wr(OFF_RESTART_CTRL, GO);
    settle;
    @(posedge mclk) rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFF_MODE_CONFIG, "mode after reset", MODE_RESET);
    chkb("fault after reset", 1'b0, wdt_fault);
    rd(OFF_FAULT_STATUS, "flags after reset", 32'h0);
    // timer off, fields left alone; scope is the opposite of the first part
    wr(OFF_MODE_CONFIG, mode_of(v, 12'h002, {1'b1, !p, 2'b10}, 2'b00));
    tk(3 * PS);
    rd(OFF_COUNT_VIEW, "off holds", view(v));
    wr(OFF_RESTART_CTRL, GO);
    settle;
    chkb("fault while off", 1'b1, wdt_fault);
    chkb("irq masked", 1'b0, wdt_irq);
    chkb("irq never seen", 1'b0, irq_seen);
    chkb("cpu reset req", 1'b1, cpu_rst_req);
    chkb("scope flipped", !p, wdt_proc_only);
    chkb("system reset req", p, sys_rst_req);
    rd(OFF_FAULT_STATUS, "error while off", 32'h2);
    // halt bits clear: debug and idle states no longer stop the count
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    wr(OFF_MODE_CONFIG, mode_of(v, v, 4'h0, 2'b00));
    @(posedge mclk) cpu_debug <= 1'b1;
    cpu_idle <= 1'b1;
    tk(2 * PS);
    rd(OFF_COUNT_VIEW, "halt bits clear", view(v - 12'h002));
    summarize;
  end
endmodule
